/* File: acqtc_consts.svh */
// Constants for the acquisition trigger control block
`ifndef ACQTC_CONSTS_SVH
`define ACQTC_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ACQTC_ADDR_CTRL      8'h00
`define ACQTC_ADDR_CMD       8'h04
`define ACQTC_ADDR_CHAN      8'h08
`define ACQTC_ADDR_LEVEL     8'h0c
`define ACQTC_ADDR_INTERVAL  8'h10
`define ACQTC_ADDR_POINTS    8'h14
`define ACQTC_ADDR_BUFSIZE   8'h18
`define ACQTC_ADDR_SOFTDLY   8'h1c
`define ACQTC_ADDR_RANGE     8'h20
`define ACQTC_ADDR_STATUS    8'h24
`define ACQTC_ADDR_ACQT_LO   8'h28
`define ACQTC_ADDR_ACQT_HI   8'h2c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ACQTC_CMD_SHOT       0
`define ACQTC_CMD_CAL        1
`define ACQTC_CHAN_TRIG_LSB  8
`define ACQTC_RANGE_CH_LSB   4

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define ACQTC_RST_CHAN_EN    8'h01
`define ACQTC_RST_INTERVAL   24'h0000fa
`define ACQTC_RST_POINTS     24'h000400
`define ACQTC_RST_BUFSIZE    24'h100000
`define ACQTC_RST_SOFTDLY    32'h017d7840
`define ACQTC_PTS_MIN        24'h000002
`define ACQTC_PTS_MAX        24'hffffff
`define ACQTC_LEVEL_MAX      8'sh63
`define ACQTC_LEVEL_MIN      (-8'sh63)
`define ACQTC_FULL_SCALE     24'sh007fff
`define ACQTC_PCT_DIV        24'sh000064

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ACQTC_CLK_MHZ        25
`define ACQTC_SAMPLE_NS      5000
`define ACQTC_GAP_NS         2000
`define ACQTC_SAMPLE_CYC     ((`ACQTC_SAMPLE_NS * `ACQTC_CLK_MHZ + 999) / 1000)
`define ACQTC_GAP_CYC        ((`ACQTC_GAP_NS * `ACQTC_CLK_MHZ + 999) / 1000)

`endif

/* File: acqtc_pkg.sv */
// Types for the acquisition trigger control block
package acqtc_pkg;

   // ----------------------------------------------------------------
   // Enumerations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {SRC_EXTERNAL, SRC_SOFTWARE, SRC_ANALOG} acqtc_src_type;
   typedef enum logic [1:0] {BUF_NO_DATA, BUF_FILLING, BUF_VALID} acqtc_buf_type;
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_ACQ, ST_DELAY} acqtc_state_type;

   // ----------------------------------------------------------------
   // Control word
   // ----------------------------------------------------------------
   typedef struct packed {
      logic          one_shot;
      logic          slope_rising;
      acqtc_src_type source;
      logic          acquisition_enable;
   } acqtc_ctrl_type;

   // Sample stream from the converter front end
   typedef struct packed {
      logic               valid;
      logic [2:0]         chan;
      logic signed [15:0] value;
   } acqtc_sample_type;

endpackage : acqtc_pkg

/* File: acqtc_range_mem.sv */
// Per-channel input range store with registered read port
`timescale 1ns/1ps
module acqtc_range_mem
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Write port
   input  wire logic        we_i,
   input  wire logic [2:0]  waddr_i,
   input  wire logic [2:0]  wdata_i,
   // Read port
   input  wire logic [2:0]  raddr_i,
   output logic      [2:0]  rdata_o,
   // All entries, straight to the front-end gain switches
   output logic      [23:0] ranges_o
);

   logic [2:0] mem_reg [8];

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_entry
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
               mem_reg[g] <= 3'h0;
            else if (we_i && waddr_i == 3'(g))
               mem_reg[g] <= wdata_i;
         end
         assign ranges_o[g*3 +: 3] = mem_reg[g];
      end
   endgenerate

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rdata_o <= 3'h0;
      else
         rdata_o <= mem_reg[raddr_i];
   end

endmodule : acqtc_range_mem

/* File: acqtc_top.sv */
// Acquisition trigger, scan sequencing and buffer status control
//
// Operation
// - Trigger source is external edge, software start or analogue threshold crossing.
// - External source starts acquisition on the edge chosen by slope.
// - Analogue source starts when trigger channel crosses threshold in slope direction.
// - Threshold is a percentage of the trigger channel's range full scale.
// - Continuous and one-shot modes work with every trigger source.
// - Continuous with edge or analogue source re-arms after each data set.
// - Continuous software mode restarts after programmable delay from previous end.
// - One-shot software: a shot command starts exactly one data set now.
// - One-shot edge or analogue: shot only arms; one set per shot.
// - Each channel holds its own bipolar range, limited by board choices.
// - Successive scans are spaced by the programmed scan interval.
// - Points per channel accepted from 2 up to two to the 24 minus one.
// - Points lowered automatically to fit the buffer, reduced value readable.
// - Acquisition time reported as scan interval times points.
// - Buffer status is no data, filling, or valid.
// - Continuous alternates filling and valid; one-shot fills once then stays valid.
// - Acquisition runs while enabled; calibration start stops it and clears enable.
// - Scan interval never below enabled-channel sample time plus fixed gap.
// - Threshold level limited to minus 99 through plus 99 percent.
`timescale 1ns/1ps
`include "acqtc_consts.svh"
module acqtc_top
   import acqtc_pkg::*;
#(
   parameter logic       ANALOG_TRIG_AVAIL = 1'b1,
   parameter logic [3:0] NUM_RANGES        = 4'h8
)
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Register port
   input  wire logic [7:0]        addr_i,
   input  wire logic [31:0]       wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [31:0]       rdata_o,
   // Trigger and converter inputs
   input  wire logic              external_trigger_input_i,
   input  wire acqtc_sample_type  sample_i,
   // Acquisition outputs
   output logic                   scan_o,
   output logic                   acq_active_o,
   output acqtc_buf_type          buf_status_o,
   output logic [23:0]            range_cfg_o,
   output logic                   acquisition_enable_o
);

   // ----------------------------------------------------------------
   // Software-visible and internal state
   // ----------------------------------------------------------------
   acqtc_ctrl_type     ctrl_reg;
   logic [7:0]         chan_en_reg;
   logic [2:0]         trig_chan_reg;
   logic signed [7:0]  level_reg;
   logic [23:0]        interval_req_reg;
   logic [23:0]        points_req_reg;
   logic [23:0]        bufsize_reg;
   logic [31:0]        softdly_reg;
   logic [2:0]         range_sel_reg;
   logic [23:0]        interval_eff_reg;
   logic [23:0]        points_eff_reg;
   logic [47:0]        acq_time_reg;
   acqtc_state_type    state_reg;
   logic [23:0]        scan_cnt_reg;
   logic [23:0]        point_cnt_reg;
   logic [31:0]        dly_cnt_reg;
   logic               ext_prev_reg;
   logic signed [15:0] trig_prev_reg;
   logic               trig_prev_ok_reg;
   logic signed [15:0] thr_code_reg;
   logic [2:0]         range_rd;

   logic wr_ctrl;
   logic wr_cmd;
   logic shot;
   logic cal_start;
   assign wr_ctrl   = wr_i && addr_i == `ACQTC_ADDR_CTRL;
   assign wr_cmd    = wr_i && addr_i == `ACQTC_ADDR_CMD;
   assign shot      = wr_cmd && wdata_i[`ACQTC_CMD_SHOT];
   assign cal_start = wr_cmd && wdata_i[`ACQTC_CMD_CAL];

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   acqtc_src_type src_next;
   always_comb
   begin
      src_next = acqtc_src_type'(wdata_i[2:1]);
      if (src_next == SRC_ANALOG && !ANALOG_TRIG_AVAIL)
         src_next = ctrl_reg.source;
      else if (wdata_i[2:1] == 2'h3)
         src_next = ctrl_reg.source;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ctrl_reg <= '{one_shot: 1'b0, slope_rising: 1'b1, source: SRC_SOFTWARE,
                       acquisition_enable: 1'b0};
      else if (cal_start)
         ctrl_reg.acquisition_enable <= 1'b0;
      else if (wr_ctrl)
      begin
         ctrl_reg.acquisition_enable <= wdata_i[0];
         ctrl_reg.source             <= src_next;
         ctrl_reg.slope_rising       <= wdata_i[3];
         ctrl_reg.one_shot           <= wdata_i[4];
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         chan_en_reg      <= `ACQTC_RST_CHAN_EN;
         trig_chan_reg    <= 3'h0;
         level_reg        <= 8'sh00;
         interval_req_reg <= `ACQTC_RST_INTERVAL;
         points_req_reg   <= `ACQTC_RST_POINTS;
         bufsize_reg      <= `ACQTC_RST_BUFSIZE;
         softdly_reg      <= `ACQTC_RST_SOFTDLY;
         range_sel_reg    <= 3'h0;
      end
      else if (wr_i)
      begin
         unique case (addr_i)
            `ACQTC_ADDR_CHAN:
            begin
               chan_en_reg   <= wdata_i[7:0];
               trig_chan_reg <= wdata_i[`ACQTC_CHAN_TRIG_LSB +: 3];
            end
            `ACQTC_ADDR_LEVEL:
            begin
               if ($signed(wdata_i) > $signed(32'(`ACQTC_LEVEL_MAX)))
                  level_reg <= `ACQTC_LEVEL_MAX;
               else if ($signed(wdata_i) < $signed(32'(`ACQTC_LEVEL_MIN)))
                  level_reg <= `ACQTC_LEVEL_MIN;
               else
                  level_reg <= wdata_i[7:0];
            end
            `ACQTC_ADDR_INTERVAL: interval_req_reg <= wdata_i[23:0];
            `ACQTC_ADDR_POINTS:   points_req_reg   <= wdata_i[23:0];
            `ACQTC_ADDR_BUFSIZE:  bufsize_reg      <= wdata_i[23:0];
            `ACQTC_ADDR_SOFTDLY:  softdly_reg      <= wdata_i;
            `ACQTC_ADDR_RANGE:    range_sel_reg    <= wdata_i[`ACQTC_RANGE_CH_LSB +: 3];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Input ranges
   // ----------------------------------------------------------------
   logic [2:0] range_wdata;
   assign range_wdata = (wdata_i[2:0] >= NUM_RANGES[2:0] && NUM_RANGES != 4'h8) ?
                        3'(NUM_RANGES - 4'h1) : wdata_i[2:0];

   acqtc_range_mem u_range_mem
   (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .we_i     (wr_i && addr_i == `ACQTC_ADDR_RANGE),
      .waddr_i  (wdata_i[`ACQTC_RANGE_CH_LSB +: 3]),
      .wdata_i  (range_wdata),
      .raddr_i  (range_sel_reg),
      .rdata_o  (range_rd),
      .ranges_o (range_cfg_o)
   );

   // ----------------------------------------------------------------
   // Derived limits
   // ----------------------------------------------------------------
   logic [3:0]  nch;
   logic [23:0] min_interval;
   logic [23:0] pts_fit;
   logic [23:0] pts_lim;
   always_comb
   begin
      nch = 4'h0;
      for (int i = 0; i < 8; i++)
         nch = nch + 4'(chan_en_reg[i]);
      if (nch == 4'h0)
         nch = 4'h1;
      min_interval = 24'(nch * `ACQTC_SAMPLE_CYC + `ACQTC_GAP_CYC);
      pts_fit = bufsize_reg / 24'(nch);
      pts_lim = points_req_reg;
      if (pts_lim < `ACQTC_PTS_MIN)
         pts_lim = `ACQTC_PTS_MIN;
      if (pts_lim > pts_fit)
         pts_lim = (pts_fit < `ACQTC_PTS_MIN) ? `ACQTC_PTS_MIN : pts_fit;
   end

   // Limits are re-evaluated every cycle, so a change of channels or buffer
   // size reshapes the next data set without software rewriting the request.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         interval_eff_reg <= `ACQTC_RST_INTERVAL;
         points_eff_reg   <= `ACQTC_RST_POINTS;
         acq_time_reg     <= 48'h0;
         thr_code_reg     <= 16'sh0000;
      end
      else
      begin
         interval_eff_reg <= (interval_req_reg < min_interval) ?
                             min_interval : interval_req_reg;
         points_eff_reg   <= pts_lim;
         acq_time_reg     <= 48'(interval_eff_reg) * 48'(points_eff_reg);
         thr_code_reg     <= 16'(24'(level_reg) * `ACQTC_FULL_SCALE
                                 / `ACQTC_PCT_DIV);
      end
   end

   // ----------------------------------------------------------------
   // Trigger detection
   // ----------------------------------------------------------------
   logic ext_edge;
   logic trig_samp;
   logic ana_cross;
   logic trig_event;
   assign ext_edge  = ctrl_reg.slope_rising ?
                      (external_trigger_input_i && !ext_prev_reg) :
                      (!external_trigger_input_i && ext_prev_reg);
   assign trig_samp = sample_i.valid && sample_i.chan == trig_chan_reg;
   // Full scale of every range maps to full code, so one code threshold serves all ranges
   assign ana_cross = trig_samp && trig_prev_ok_reg &&
                      (ctrl_reg.slope_rising ?
                       (trig_prev_reg <  thr_code_reg && sample_i.value >= thr_code_reg) :
                       (trig_prev_reg >  thr_code_reg && sample_i.value <= thr_code_reg));
   assign trig_event = (ctrl_reg.source == SRC_EXTERNAL) ? ext_edge :
                       (ctrl_reg.source == SRC_ANALOG && ANALOG_TRIG_AVAIL) ? ana_cross :
                       1'b0;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ext_prev_reg     <= 1'b0;
         trig_prev_reg    <= 16'sh0000;
         trig_prev_ok_reg <= 1'b0;
      end
      else
      begin
         ext_prev_reg <= external_trigger_input_i;
         if (state_reg != ST_ARMED)
            trig_prev_ok_reg <= 1'b0;
         else if (trig_samp)
         begin
            trig_prev_reg    <= sample_i.value;
            trig_prev_ok_reg <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   logic scan_due;
   logic set_done;
   assign scan_due = scan_cnt_reg == 24'h0;
   assign set_done = state_reg == ST_ACQ && scan_due && point_cnt_reg == points_eff_reg;

   always_ff @(posedge clk_i)
   begin
      if (rst_i || !ctrl_reg.acquisition_enable || cal_start)
         state_reg <= ST_IDLE;
      else
      begin
         unique case (state_reg)
            ST_IDLE:
            begin
               if (!ctrl_reg.one_shot)
                  state_reg <= (ctrl_reg.source == SRC_SOFTWARE) ? ST_ACQ : ST_ARMED;
               else if (shot)
                  state_reg <= (ctrl_reg.source == SRC_SOFTWARE) ? ST_ACQ :
                               ST_ARMED;
            end
            ST_ARMED:
            begin
               if (ctrl_reg.source == SRC_SOFTWARE)
                  state_reg <= ST_IDLE;
               else if (trig_event)
                  state_reg <= ST_ACQ;
            end
            ST_ACQ:
            begin
               if (set_done)
               begin
                  if (ctrl_reg.one_shot)
                     state_reg <= ST_IDLE;
                  else if (ctrl_reg.source == SRC_SOFTWARE)
                     state_reg <= ST_DELAY;
                  else
                     state_reg <= ST_ARMED;
               end
            end
            ST_DELAY:
            begin
               if (ctrl_reg.one_shot || ctrl_reg.source != SRC_SOFTWARE)
                  state_reg <= ST_IDLE;
               else if (dly_cnt_reg >= softdly_reg)
                  state_reg <= ST_ACQ;
            end
         endcase
      end
   end

   // Scan pacing: first scan at once, then one per interval
   always_ff @(posedge clk_i)
   begin
      if (rst_i || state_reg != ST_ACQ || !ctrl_reg.acquisition_enable || cal_start)
      begin
         scan_cnt_reg  <= 24'h0;
         point_cnt_reg <= 24'h0;
         scan_o        <= 1'b0;
      end
      else
      begin
         scan_o <= scan_due && point_cnt_reg != points_eff_reg;
         if (scan_due)
         begin
            scan_cnt_reg  <= interval_eff_reg - 24'h1;
            point_cnt_reg <= point_cnt_reg + 24'h1;
         end
         else
            scan_cnt_reg <= scan_cnt_reg - 24'h1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i || state_reg != ST_DELAY)
         dly_cnt_reg <= 32'h1;
      else
         dly_cnt_reg <= dly_cnt_reg + 32'h1;
   end

   // ----------------------------------------------------------------
   // Buffer status
   // ----------------------------------------------------------------
   // A stopped acquisition leaves a partial buffer, so it no longer counts as valid
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         buf_status_o <= BUF_NO_DATA;
      else if (state_reg == ST_ACQ && (!ctrl_reg.acquisition_enable || cal_start))
         buf_status_o <= BUF_NO_DATA;
      else if (set_done)
         buf_status_o <= BUF_VALID;
      else if (state_reg == ST_ACQ)
         buf_status_o <= BUF_FILLING;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         acq_active_o         <= 1'b0;
         acquisition_enable_o <= 1'b0;
      end
      else
      begin
         acq_active_o         <= state_reg == ST_ACQ && !set_done;
         acquisition_enable_o <= ctrl_reg.acquisition_enable;
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rdata_o <= 32'h0;
      else if (rd_i)
      begin
         unique case (addr_i)
            `ACQTC_ADDR_CTRL:     rdata_o <= {27'h0, ctrl_reg};
            `ACQTC_ADDR_CHAN:     rdata_o <= {21'h0, trig_chan_reg, chan_en_reg};
            `ACQTC_ADDR_LEVEL:    rdata_o <= 32'(level_reg);
            `ACQTC_ADDR_INTERVAL: rdata_o <= {8'h0, interval_eff_reg};
            `ACQTC_ADDR_POINTS:   rdata_o <= {8'h0, points_eff_reg};
            `ACQTC_ADDR_BUFSIZE:  rdata_o <= {8'h0, bufsize_reg};
            `ACQTC_ADDR_SOFTDLY:  rdata_o <= softdly_reg;
            `ACQTC_ADDR_RANGE:    rdata_o <= {25'h0, range_sel_reg, 1'b0, range_rd};
            `ACQTC_ADDR_STATUS:   rdata_o <= {27'h0, ANALOG_TRIG_AVAIL, state_reg,
                                              buf_status_o};
            `ACQTC_ADDR_ACQT_LO:  rdata_o <= acq_time_reg[31:0];
            `ACQTC_ADDR_ACQT_HI:  rdata_o <= {16'h0, acq_time_reg[47:32]};
            default:              rdata_o <= 32'h0;
         endcase
      end
      else
         rdata_o <= 32'h0;
   end

endmodule : acqtc_top

/* File: acqtc_far_model.sv */
// Model of the external trigger source and the analogue front end
`timescale 1ns/1ps
module acqtc_far_model
   import acqtc_pkg::*;
(
   // Clock and bench controls
   input  wire logic               clk_i,
   input  wire logic               trig_lvl_i,
   input  wire logic signed [15:0] ana_i,
   // Lines into the block
   output logic                    external_trigger_input_o,
   output acqtc_sample_type        sample_o
);
   logic [5:0] cnt_reg = 6'h00;
   initial external_trigger_input_o = 1'b0;
   initial sample_o = '0;
   // Logic-level trigger, only ever changed just after an edge
   always @(posedge clk_i)
      external_trigger_input_o <= trig_lvl_i;
   // One sample each eighth cycle, channels in turn; spare channels carry noise
   always @(posedge clk_i)
   begin
      cnt_reg <= cnt_reg + 6'h01;
      sample_o <= '{cnt_reg[2:0] == 3'h0, cnt_reg[5:3],
                    (cnt_reg[5:3] == 3'h0) ? ana_i : 16'($urandom)};
   end
endmodule : acqtc_far_model

/* File: acqtc_top_sva.sv */
// Port assertions for the acquisition trigger control block
`timescale 1ns/1ps
`include "acqtc_consts.svh"
module acqtc_top_sva
   import acqtc_pkg::*;
(
   // Watched ports
   input wire logic          clk_i,
   input wire logic          rst_i,
   input wire logic [7:0]    addr_i,
   input wire logic [31:0]   wdata_i,
   input wire logic          wr_i,
   input wire logic          rd_i,
   input wire logic [31:0]   rdata_o,
   input wire logic          scan_o,
   input wire logic          acq_active_o,
   input wire acqtc_buf_type buf_status_o,
   input wire logic [23:0]   range_cfg_o,
   input wire logic          acquisition_enable_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_cal;
      wr_i && addr_i == `ACQTC_ADDR_CMD && wdata_i[`ACQTC_CMD_CAL];
   endsequence
   sequence s_done;
      $fell(acq_active_o) && acquisition_enable_o;
   endsequence
   property p_first;
      $rose(acq_active_o) |-> scan_o;
   endproperty
   a_first: assert property (p_first) else $error("no scan at set start");
   property p_fill;
      scan_o |-> acq_active_o && buf_status_o == BUF_FILLING;
   endproperty
   a_fill: assert property (p_fill) else $error("scan outside filling");
   property p_gap;
      scan_o |=> !scan_o [*8];
   endproperty
   a_gap: assert property (p_gap) else $error("scans too close");
   property p_done;
      s_done |-> ##[0:1] buf_status_o == BUF_VALID;
   endproperty
   a_done: assert property (p_done) else $error("set end without valid");
   property p_cal;
      s_cal |=> ##[0:1] (!acquisition_enable_o && !acq_active_o);
   endproperty
   a_cal: assert property (p_cal) else $error("calibration did not stop");
   property p_en;
      wr_i && addr_i == `ACQTC_ADDR_CTRL ##1 !wr_i
         |=> acquisition_enable_o == $past(wdata_i[0], 2);
   endproperty
   a_en: assert property (p_en) else $error("enable not written");
   property p_off;
      !acquisition_enable_o [*2] |-> !scan_o;
   endproperty
   a_off: assert property (p_off) else $error("scan while disabled");
   property p_rng;
      !$past(wr_i) && !$past(wr_i, 2) && !$past(wr_i, 3) |-> $stable(range_cfg_o);
   endproperty
   a_rng: assert property (p_rng) else $error("range moved without write");
   property p_rd;
      !rd_i |=> rdata_o == 32'h0;
   endproperty
   a_rd: assert property (p_rd) else $error("read data outside answer");
endmodule : acqtc_top_sva
bind acqtc_top acqtc_top_sva u_sva (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
   .scan_o, .acq_active_o, .buf_status_o, .range_cfg_o, .acquisition_enable_o);

/* File: acqtc_top_tb.sv */
// Self-checking bench for the acquisition trigger control block
`timescale 1ns/1ps
`include "acqtc_consts.svh"
module acqtc_top_tb
   import acqtc_pkg::*;
;
   localparam int NR = 4;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic trig = 1'b0;
   logic signed [15:0] ana = 16'hfc18;
   logic [31:0] rdata_o;
   logic ext, scan_o, acq_active_o, acquisition_enable_o;
   logic [23:0] range_cfg_o;
   acqtc_sample_type smp;
   acqtc_buf_type buf_status_o;
   int err_count = 0;
   int cmp_count = 0;
   int scans = 0;
   int cyc = 0;
   int reqs[$] = '{1, 100, 3};
   acqtc_top #(.NUM_RANGES(4'(NR))) dut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
      .rdata_o, .external_trigger_input_i(ext), .sample_i(smp), .scan_o, .acq_active_o,
      .buf_status_o, .range_cfg_o, .acquisition_enable_o);
   acqtc_far_model far (.clk_i, .trig_lvl_i(trig), .ana_i(ana),
      .external_trigger_input_o(ext), .sample_o(smp));
   initial forever #20 clk_i = ~clk_i;
   always @(posedge clk_i) scans <= scans + int'(scan_o);
   // Hang guard, well above the six thousand cycles the run needs
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         err_count++;
         end_of_test;
      end
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
   endtask : wr
   task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(posedge clk_i);
      chk(n, rdata_o, e);
   endtask : rdchk
   function automatic int exp_pts(int req, int bsz, int nch);
      int lim = (bsz / nch < 2) ? 2 : bsz / nch;
      req = (req < 2) ? 2 : req;
      return (req > lim) ? lim : req;
   endfunction : exp_pts
   function automatic int exp_int(int req, int nch);
      int m = nch * `ACQTC_SAMPLE_CYC + `ACQTC_GAP_CYC;
      return (req < m) ? m : req;
   endfunction : exp_int
   // Waits for one whole data set; gap is the wait before it started
   task automatic wait_set(output int gap);
      int n = 0;
      gap = 0;
      while (acq_active_o !== 1'b1 && gap < 3000) @(posedge clk_i) gap++;
      while (acq_active_o !== 1'b0 && n < 3000) @(posedge clk_i) n++;
      if (gap == 3000 || n == 3000) err_count++;
      @(posedge clk_i);
   endtask : wait_set
   // Trigger action tr: 1 toggles the edge line, 2 lifts the analogue level,
   // 3 also throws a rising edge into the running set
   task automatic run(input string n, input logic [31:0] c, input int tr, output int g);
      int s0 = scans;
      wr(`ACQTC_ADDR_CTRL, c & 32'hfffffffe);
      wr(`ACQTC_ADDR_CTRL, c);
      if (c[4]) wr(`ACQTC_ADDR_CMD, 32'h1);
      repeat (80) @(posedge clk_i);
      if (tr == 1 || tr == 3) trig <= ~trig;
      if (tr == 2) ana <= 16'h4e20;
      if (tr == 3)
      begin
         repeat (200) @(posedge clk_i);
         trig <= 1'b0;
         repeat (10) @(posedge clk_i);
         trig <= 1'b1;
      end
      wait_set(g);
      chk(n, 32'(scans - s0), 32'h3);
      chk(n, 32'(buf_status_o), 32'(BUF_VALID));
   endtask : run
   initial
   begin
      int g, v;
      v = $urandom(14162);
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rdchk("ctrl", `ACQTC_ADDR_CTRL, 32'ha);
      rdchk("status", `ACQTC_ADDR_STATUS, 32'h10);
      rdchk("unmapped", 8'h30, 32'h0);
      wr(`ACQTC_ADDR_LEVEL, 32'hffffff88);
      rdchk("level", `ACQTC_ADDR_LEVEL, 32'hffffff9d);
      wr(`ACQTC_ADDR_CHAN, 32'h3);
      wr(`ACQTC_ADDR_BUFSIZE, 32'ha);
      wr(`ACQTC_ADDR_INTERVAL, 32'h5);
      foreach (reqs[i])
      begin
         wr(`ACQTC_ADDR_POINTS, 32'(reqs[i]));
         repeat (3) @(posedge clk_i);
         rdchk("points", `ACQTC_ADDR_POINTS, 32'(exp_pts(reqs[i], 10, 2)));
      end
      rdchk("interval", `ACQTC_ADDR_INTERVAL, 32'(exp_int(5, 2)));
      rdchk("time", `ACQTC_ADDR_ACQT_LO, 32'(exp_int(5, 2) * exp_pts(3, 10, 2)));
      wr(`ACQTC_ADDR_CHAN, 32'h1);
      wr(`ACQTC_ADDR_BUFSIZE, 32'h100000);
      wr(`ACQTC_ADDR_INTERVAL, 32'hc8);
      wr(`ACQTC_ADDR_SOFTDLY, 32'h28);
      wr(`ACQTC_ADDR_LEVEL, 32'h32);
      run("shot sw", 32'h1b, 0, g);
      rdchk("idle", `ACQTC_ADDR_STATUS, 32'h12);
      for (int s = 1; s >= 0; s--)
      begin
         trig <= ~s[0];
         run("shot ext", 32'h11 | 32'(s << 3), 1, g);
      end
      v = scans;
      repeat (2) @(posedge clk_i) trig <= ~trig;
      repeat (300) @(posedge clk_i);
      chk("one set", 32'(scans - v), 32'h0);
      run("shot analog", 32'h1d, 2, g);
      trig <= 1'b0;
      run("cont ext", 32'h09, 3, g);
      rdchk("rearmed", `ACQTC_ADDR_STATUS, 32'h16);
      trig <= 1'b0;
      run("cont ext", 32'h09, 1, g);
      run("cont sw", 32'h0b, 0, g);
      wait_set(g);
      chk("delay", 32'(g >= 36 && g <= 44), 32'h1);
      g = 0;
      while (acq_active_o !== 1'b1 && g < 200) @(posedge clk_i) g++;
      wr(`ACQTC_ADDR_CMD, 32'h2);
      @(posedge clk_i);
      chk("enable", 32'(acquisition_enable_o), 32'h0);
      chk("buffer", 32'(buf_status_o), 32'(BUF_NO_DATA));
      repeat (4)
      begin
         v = $urandom;
         wr(`ACQTC_ADDR_RANGE, {25'h0, v[6:4], 1'b0, v[2:0]});
         repeat (3) @(posedge clk_i);
         chk("range", 32'(range_cfg_o[v[6:4] * 3 +: 3]), 32'((v[2:0] < NR) ? v[2:0] : NR - 1));
      end
      end_of_test;
   end
   task end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test
endmodule : acqtc_top_tb
